// >>> include/lbpc_defines.vh
// constants for the local bus pin control block
`ifndef LBPC_DEFINES_VH
`define LBPC_DEFINES_VH
`define LBPC_RESET_FETCH_ADDR 20'hffff0
`define LBPC_HALT_VECTOR      8'h02
`define LBPC_STAT_PASSIVE     3'h7
`define LBPC_STAT_READ        3'h5
`define LBPC_STAT_WRITE       3'h6
`define LBPC_STAT_FETCH       3'h4
`endif

// >>> hw/lbpc_bus.v
// local bus cycle engine with pin state control
`timescale 1ns/10ps
`default_nettype none
`include "lbpc_defines.vh"
module lbpc_bus (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        osc_input,
    input  wire        reset_input_n,
    input  wire        ready_in,
    input  wire        ready_ignore,
    input  wire        hold_req,
    input  wire        nmi_in,
    input  wire        test_busy_n,
    input  wire        idle_req,
    input  wire        powerdown_req,
    input  wire        req_valid,
    input  wire        req_write,
    input  wire        req_lock,
    input  wire        req_wait,
    input  wire [19:0] req_addr,
    input  wire [1:0]  req_lanes,
    input  wire [15:0] req_wdata,
    input  wire [15:0] muxed_addr_data_in,
    input  wire        addr_msb_float_select_in,
    output reg         req_ready,
    output reg         rsp_valid,
    output reg  [15:0] rsp_rdata,
    output reg         nmi_service,
    output reg  [7:0]  nmi_vector,
    output reg         wait_halted,
    output reg         bus_clock_output,
    output reg         reset_indicator,
    output reg         all_float_test_mode,
    output reg         hold_ack,
    output reg  [15:0] muxed_addr_data_out,
    output reg  [15:0] muxed_addr_data_oe,
    output reg  [3:0]  upper_address,
    output reg  [3:0]  upper_address_oe,
    output reg  [3:0]  upper_address_weak_high,
    output reg  [2:0]  cycle_status,
    output reg         cycle_status_oe,
    output reg         addr_latch_strobe,
    output reg         upper_byte_enable_n,
    output reg         upper_byte_enable_oe,
    output reg         read_strobe_n,
    output reg         write_strobe_n,
    output reg         strobe_oe,
    output reg         xcvr_data_enable_n,
    output reg         xcvr_data_enable_oe,
    output reg         buffer_direction,
    output reg         buffer_direction_oe,
    output reg         lock_n,
    output reg         lock_oe,
    output reg         lock_weak_high
);
    localparam [5:0] ST_RST  = 6'h01;
    localparam [5:0] ST_IDLE = 6'h02;
    localparam [5:0] ST_ADDR = 6'h04;
    localparam [5:0] ST_DATA = 6'h08;
    localparam [5:0] ST_HOLD = 6'h10;
    localparam [5:0] ST_WAIT = 6'h20;

    // two-stage synchronisers for the osc, reset, ready, hold, nmi, test and msb select inputs
    reg [6:0] sync1;
    reg [6:0] sync2;
    always @(posedge sys_clk) begin
        sync1 <= {osc_input, reset_input_n, ready_in, hold_req, nmi_in, test_busy_n,
                  addr_msb_float_select_in};
        sync2 <= sync1;
    end
    wire osc_s   = sync2[6];
    wire reset_input_n_s = sync2[5];
    wire rdy_s   = sync2[4];
    wire hold_s  = sync2[3];
    wire nmi_s   = sync2[2];
    wire test_s  = sync2[1];
    wire msb_s   = sync2[0];

    reg        osc_d;
    reg        nmi_d;
    reg        reset_input_n_d;
    reg [5:0]  state;
    reg        cur_write;
    reg        cur_lock;
    reg [19:0] cur_addr;
    reg [1:0]  cur_lanes;
    reg [15:0] cur_wdata;
    reg        fetch_pending;
    wire osc_fall  = osc_d & ~osc_s;
    wire in_reset  = srst | ~reset_input_n_s;
    wire rise_rst  = reset_input_n_s & ~reset_input_n_d;
    wire bus_edge  = osc_fall & bus_clock_output;
    wire hold_grant = bus_edge & (state == ST_IDLE) & hold_s & ~cur_lock;

    function [1:0] lane_code;
        input [1:0] lanes;
        input       a0;
        begin
            // {upper_byte_enable_n, a0}: 00 word, 01 upper, 10 lower
            case (lanes)
                2'b11:   lane_code = 2'b00;
                2'b10:   lane_code = 2'b01;
                default: lane_code = {1'b1, a0};
            endcase
        end
    endfunction
    wire [1:0] lc = lane_code(cur_lanes, cur_addr[0]);

    always @(posedge sys_clk) begin
        osc_d   <= osc_s;
        nmi_d   <= nmi_s;
        reset_input_n_d <= reset_input_n_s;
        if (in_reset) begin
            bus_clock_output <= 1'b0;
        end else if (rise_rst) begin
            bus_clock_output <= 1'b0;
        end else if (osc_fall) begin
            bus_clock_output <= ~bus_clock_output;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            all_float_test_mode <= 1'b0;
        end else if (~reset_input_n_s) begin
            all_float_test_mode <= ~msb_s;
        end
    end

    always @(posedge sys_clk) begin
        if (in_reset) begin
            state <= ST_RST;
            reset_indicator <= 1'b1;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            wait_halted <= 1'b0;
            hold_ack <= 1'b0;
            cur_write <= 1'b0;
            cur_lock <= 1'b0;
            cur_addr <= 20'h00000;
            cur_lanes <= 2'b00;
            cur_wdata <= 16'h0000;
            fetch_pending <= 1'b0;
            nmi_service <= 1'b0;
            nmi_vector <= 8'h00;
        end else begin
            reset_indicator <= 1'b0;
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
            nmi_service <= 1'b0;
            if (nmi_s & ~nmi_d) begin
                nmi_service <= 1'b1;
                nmi_vector <= `LBPC_HALT_VECTOR;
            end
            if (state == ST_RST) begin
                fetch_pending <= 1'b1;
            end else if (bus_edge & (state == ST_ADDR)) begin
                fetch_pending <= 1'b0;
            end
            if (bus_edge) begin
                case (state)
                    ST_RST: state <= ST_IDLE;
                    ST_IDLE: begin
                        if (hold_grant) begin
                            state <= ST_HOLD;
                            hold_ack <= 1'b1;
                        end else if (fetch_pending) begin
                            cur_addr <= `LBPC_RESET_FETCH_ADDR;
                            cur_write <= 1'b0;
                            cur_lanes <= 2'b11;
                            state <= ST_ADDR;
                        end else if (req_valid & req_wait) begin
                            req_ready <= 1'b1;
                            wait_halted <= 1'b1;
                            state <= ST_WAIT;
                        end else if (req_valid & ~powerdown_req) begin
                            req_ready <= 1'b1;
                            cur_addr <= req_addr;
                            cur_write <= req_write;
                            cur_lock <= req_lock;
                            cur_lanes <= req_lanes;
                            cur_wdata <= req_wdata;
                            state <= ST_ADDR;
                        end
                    end
                    ST_ADDR: state <= ST_DATA;
                    ST_DATA: begin
                        if (rdy_s | ready_ignore) begin
                            rsp_valid <= 1'b1;
                            rsp_rdata <= muxed_addr_data_in;
                            if (~req_lock) begin
                                cur_lock <= 1'b0;
                            end
                            state <= ST_IDLE;
                        end
                    end
                    ST_HOLD: begin
                        if (~hold_s) begin
                            hold_ack <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                    ST_WAIT: begin
                        if (~test_s) begin
                            wait_halted <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                    default: state <= ST_RST;
                endcase
            end
        end
    end

    // pin drive, held on powerdown while in ST_IDLE
    always @(posedge sys_clk) begin
        if (all_float_test_mode) begin
            muxed_addr_data_oe <= 16'h0000;
            upper_address_oe <= 4'h0;
            upper_address_weak_high <= 4'h0;
            cycle_status_oe <= 1'b0;
            upper_byte_enable_oe <= 1'b0;
            strobe_oe <= 1'b0;
            xcvr_data_enable_oe <= 1'b0;
            buffer_direction_oe <= 1'b0;
            lock_oe <= 1'b0;
            lock_weak_high <= 1'b0;
            addr_latch_strobe <= 1'b0;
            muxed_addr_data_out <= 16'h0000;
            upper_address <= 4'h0;
            cycle_status <= `LBPC_STAT_PASSIVE;
            upper_byte_enable_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            xcvr_data_enable_n <= 1'b1;
            buffer_direction <= 1'b0;
            lock_n <= 1'b1;
        end else if (in_reset | state == ST_RST) begin
            muxed_addr_data_oe <= 16'h0000;
            upper_address_oe <= 4'h0;
            upper_address_weak_high <= 4'hf;
            cycle_status_oe <= 1'b0;
            upper_byte_enable_oe <= 1'b0;
            strobe_oe <= 1'b0;
            xcvr_data_enable_oe <= 1'b0;
            buffer_direction_oe <= 1'b0;
            lock_oe <= 1'b0;
            lock_weak_high <= 1'b1;
            addr_latch_strobe <= 1'b0;
            muxed_addr_data_out <= 16'h0000;
            upper_address <= 4'h0;
            cycle_status <= `LBPC_STAT_PASSIVE;
            upper_byte_enable_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            xcvr_data_enable_n <= 1'b1;
            buffer_direction <= 1'b0;
            lock_n <= 1'b1;
        end else if (state == ST_HOLD || hold_grant) begin
            muxed_addr_data_oe <= 16'h0000;
            upper_address_oe <= 4'h0;
            upper_address_weak_high <= 4'h0;
            cycle_status_oe <= 1'b0;
            upper_byte_enable_oe <= 1'b0;
            strobe_oe <= 1'b0;
            xcvr_data_enable_oe <= 1'b0;
            buffer_direction_oe <= 1'b0;
            lock_oe <= 1'b0;
            lock_weak_high <= 1'b0;
            addr_latch_strobe <= 1'b0;
        end else if (~powerdown_req | state != ST_IDLE) begin
            upper_address_weak_high <= 4'h0;
            lock_weak_high <= 1'b0;
            cycle_status_oe <= 1'b1;
            upper_byte_enable_oe <= 1'b1;
            strobe_oe <= 1'b1;
            xcvr_data_enable_oe <= 1'b1;
            buffer_direction_oe <= 1'b1;
            lock_oe <= 1'b1;
            upper_address_oe <= 4'hf;
            lock_n <= ~(cur_lock & state != ST_IDLE) | idle_req;
            addr_latch_strobe <= (state == ST_ADDR) & ~bus_clock_output;
            if (state == ST_ADDR) begin
                muxed_addr_data_oe <= 16'hffff;
                muxed_addr_data_out <= cur_addr[15:0];
                upper_address <= cur_addr[19:16];
                upper_byte_enable_n <= lc[1];
                cycle_status <= cur_write ? `LBPC_STAT_WRITE :
                                (fetch_pending ? `LBPC_STAT_FETCH : `LBPC_STAT_READ);
                buffer_direction <= cur_write;
                xcvr_data_enable_n <= 1'b1;
            end else if (state == ST_DATA) begin
                upper_address <= 4'h0;
                muxed_addr_data_oe <= cur_write ? 16'hffff : 16'h0000;
                muxed_addr_data_out <= cur_wdata;
                read_strobe_n <= cur_write;
                write_strobe_n <= ~cur_write;
                xcvr_data_enable_n <= 1'b0;
                cycle_status <= `LBPC_STAT_PASSIVE;
            end else begin
                // idle or wait: strobes and xcvr enable high, status passive, AD released, address lines keep their value
                read_strobe_n <= 1'b1;
                write_strobe_n <= 1'b1;
                xcvr_data_enable_n <= 1'b1;
                cycle_status <= `LBPC_STAT_PASSIVE;
                muxed_addr_data_oe <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/lbpc_bus_sva.sv
// assertions on the local bus pin control ports
`timescale 1ns/10ps
`default_nettype none
module lbpc_bus_sva (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        ready_in,
    input wire logic        ready_ignore,
    input wire logic        rsp_valid,
    input wire logic        nmi_service,
    input wire logic [7:0]  nmi_vector,
    input wire logic        bus_clock_output,
    input wire logic        reset_indicator,
    input wire logic        hold_ack,
    input wire logic [15:0] muxed_addr_data_oe,
    input wire logic [3:0]  upper_address,
    input wire logic [3:0]  upper_address_weak_high,
    input wire logic        addr_latch_strobe,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic        strobe_oe,
    input wire logic        buffer_direction,
    input wire logic        lock_n,
    input wire logic        lock_oe,
    input wire logic        lock_weak_high
);
    default clocking cb @(posedge sys_clk); endclocking
    chk_reset_levels: assert property (srst |=> reset_indicator && !strobe_oe
        && muxed_addr_data_oe == 16'h0000) else $error("reset levels wrong");
    chk_reset_weak: assert property (srst |=> upper_address_weak_high == 4'hf
        && lock_weak_high && !addr_latch_strobe) else $error("reset weak levels wrong");
    chk_hold_float: assert property (disable iff (srst) hold_ack |-> !strobe_oe && !lock_oe
        && !addr_latch_strobe && muxed_addr_data_oe == 16'h0000) else $error("hold not floated");
    chk_hold_lock: assert property (disable iff (srst) $rose(hold_ack)
        |-> $past(lock_n) || !$past(lock_oe)) else $error("hold granted under lock");
    chk_clk_half: assert property (disable iff (srst || reset_indicator)
        $changed(bus_clock_output) |=> $stable(bus_clock_output)[*3]) else $error("bus clock fast");
    chk_write_drive: assert property (disable iff (srst) !write_strobe_n && strobe_oe
        |-> buffer_direction && muxed_addr_data_oe != 16'h0000) else $error("write not driven");
    chk_read_release: assert property (disable iff (srst) !read_strobe_n && strobe_oe
        |-> !buffer_direction && muxed_addr_data_oe == 16'h0000) else $error("read bus driven");
    chk_upper_zero: assert property (disable iff (srst) (!read_strobe_n || !write_strobe_n)
        && strobe_oe |-> upper_address == 4'h0 && !addr_latch_strobe) else $error("upper not zero");
    chk_ready_wait: assert property (disable iff (srst) (!ready_in && !ready_ignore)[*3]
        |=> !rsp_valid) else $error("cycle ended without ready");
    chk_nmi_type: assert property (disable iff (srst) nmi_service
        |-> nmi_vector == 8'h02) else $error("nmi vector wrong");
endmodule
bind lbpc_bus lbpc_bus_sva lbpc_bus_sva_i (.*);
`default_nettype wire

// >>> tb/lbpc_mem_model.sv
// external memory model for the local bus
`timescale 1ns/10ps
`default_nettype none
module lbpc_mem_model (
    input  wire logic        sys_clk,
    input  wire logic [1:0]  pace,
    input  wire logic [15:0] ad_out,
    input  wire logic [3:0]  upper_address,
    input  wire logic        addr_latch_strobe,
    input  wire logic        read_strobe_n,
    input  wire logic        write_strobe_n,
    output logic      [15:0] ad_in,
    output logic             ready_in
);
    logic [15:0] mem [0:255];
    logic [19:0] addr = 20'h00000;
    logic [15:0] last = 16'h0000;
    int          cnt = 0;
    initial ready_in = 1'b0;
    always @* if (addr_latch_strobe) addr = {upper_address, ad_out};
    // released bus shows the inverse of the last value
    always @* ad_in = read_strobe_n ? ~last : mem[addr[8:1]];
    // pace 0 prompt, 1 slow, 2 never ready
    always @(posedge sys_clk) begin
        if (!read_strobe_n)
            last <= ad_in;
        if (!write_strobe_n)
            mem[addr[8:1]] <= ad_out;
        cnt <= (read_strobe_n && write_strobe_n) ? 0 : cnt + 1;
        ready_in <= pace != 2'd2 && cnt >= (pace == 2'd1 ? 5 : 0)
            && !(read_strobe_n && write_strobe_n);
    end
endmodule
`default_nettype wire

// >>> tb/tb_lbpc_bus.sv
// self-checking bench for the local bus cycle engine
`timescale 1ns/10ps
`default_nettype none
`include "lbpc_defines.vh"
module tb_lbpc_bus;
    logic sys_clk = 0, srst = 1, osc_input = 0, reset_input_n = 1, ready_ignore = 0;
    logic hold_req = 0, nmi_in = 0, test_busy_n = 1, idle_req = 0, powerdown_req = 0;
    logic req_valid = 0, req_write = 0, req_lock = 0, req_wait = 0, addr_msb_float_select_in = 1;
    logic [19:0] req_addr = 0;
    logic [1:0]  req_lanes = 0, pace = 0;
    logic [15:0] req_wdata = 0;
    logic [16:0] note;
    logic [16:0] notes[$];
    int          n_fail = 0, total_checks = 0, seed = 60785;
    wire logic ready_in, req_ready, rsp_valid, nmi_service, wait_halted, bus_clock_output;
    wire logic reset_indicator, all_float_test_mode, hold_ack, cycle_status_oe, addr_latch_strobe;
    wire logic upper_byte_enable_n, upper_byte_enable_oe, read_strobe_n, write_strobe_n, strobe_oe;
    wire logic xcvr_data_enable_n, xcvr_data_enable_oe, buffer_direction, buffer_direction_oe;
    wire logic lock_n, lock_oe, lock_weak_high;
    wire logic [15:0] muxed_addr_data_in, rsp_rdata, muxed_addr_data_out, muxed_addr_data_oe;
    wire logic [7:0]  nmi_vector;
    wire logic [3:0]  upper_address, upper_address_oe, upper_address_weak_high;
    wire logic [2:0]  cycle_status;
    lbpc_bus lbpc_bus_i (.*);
    lbpc_mem_model lbpc_mem_model_i (.sys_clk(sys_clk), .pace(pace), .ad_out(muxed_addr_data_out),
        .upper_address(upper_address), .addr_latch_strobe(addr_latch_strobe),
        .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
        .ad_in(muxed_addr_data_in), .ready_in(ready_in));
    initial forever #10 sys_clk = ~sys_clk;
    initial forever begin
        repeat (4) @(negedge sys_clk);
        osc_input = ~osc_input;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        total_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic give_up(input int k);
        if (k >= 200) begin
            n_fail++;
            $display("wait ran out at t=%0t", $time);
            report_and_stop();
        end
    endtask
    task automatic fetch_check;
        int k;
        for (k = 0; k < 200 && addr_latch_strobe !== 1'b1; k++) @(negedge sys_clk);
        give_up(k);
        check({upper_address, muxed_addr_data_out}, 20'hffff0);
        check(cycle_status, `LBPC_STAT_FETCH);
    endtask
    task automatic do_req(input logic wr, input logic lk, input logic [19:0] a,
                          input logic [1:0] ln, input logic [15:0] d);
        int k;
        @(negedge sys_clk);
        req_valid = 1;
        req_write = wr;
        req_lock = lk;
        req_addr = a;
        req_lanes = ln;
        req_wdata = d;
        for (k = 0; k < 200; k++) begin
            @(negedge sys_clk);
            if (req_ready === 1'b1)
                break;
        end
        give_up(k);
        notes.push_back({~wr, d});
        req_valid = 0;
        req_lock = 0;
        for (k = 0; k < 200 && addr_latch_strobe !== 1'b1; k++) @(negedge sys_clk);
        give_up(k);
        check({upper_byte_enable_n, upper_address, muxed_addr_data_out}, {~ln[1], a});
        check(cycle_status, wr ? `LBPC_STAT_WRITE : `LBPC_STAT_READ);
    endtask
    always @(negedge sys_clk) begin
        if (rsp_valid === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note[16])
                check(rsp_rdata, note[15:0]);
        end
    end
    initial begin
        int i, k;
        logic [15:0] d, snap;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) srst = 0;
        fetch_check();
        for (i = 0; i < 4; i++) begin
            pace = (i == 3) ? 2'd2 : 2'(i & 1);
            ready_ignore = (i == 3);
            d = 16'($random(seed));
            do_req(1, 0, 20'(16 + 2 * i), 2'b11, d);
            do_req(0, 0, 20'(16 + 2 * i), 2'b11, d);
        end
        pace = 0;
        ready_ignore = 0;
        do_req(1, 0, 20'h00021, 2'b10, d);
        do_req(1, 0, 20'h00022, 2'b01, d);
        $display("test traffic done");
        do_req(1, 1, 20'h00040, 2'b11, d);
        hold_req = 1;
        for (k = 0; k < 200 && hold_ack !== 1'b1; k++) @(negedge sys_clk);
        give_up(k);
        check({reset_indicator, lock_oe}, 2'b00);
        hold_req = 0;
        nmi_in = 1;
        for (k = 0; k < 200 && nmi_service !== 1'b1; k++) @(negedge sys_clk);
        give_up(k);
        check(nmi_vector, `LBPC_HALT_VECTOR);
        nmi_in = 0;
        req_valid = 1;
        req_wait = 1;
        for (k = 0; k < 200 && wait_halted !== 1'b1; k++) @(negedge sys_clk);
        give_up(k);
        req_valid = 0;
        req_wait = 0;
        repeat (20) @(negedge sys_clk);
        check(wait_halted, 1);
        test_busy_n = 0;
        for (k = 0; k < 200 && wait_halted !== 1'b0; k++) @(negedge sys_clk);
        give_up(k);
        test_busy_n = 1;
        $display("test hold nmi wait done");
        idle_req = 1;
        repeat (20) @(negedge sys_clk);
        check({read_strobe_n, write_strobe_n, xcvr_data_enable_n, lock_n, cycle_status,
               addr_latch_strobe, reset_indicator}, {4'hf, 3'h7, 2'b00});
        check({cycle_status_oe, upper_byte_enable_oe, xcvr_data_enable_oe,
               buffer_direction_oe, upper_address_oe}, 8'hff);
        snap = muxed_addr_data_out;
        powerdown_req = 1;
        idle_req = 0;
        repeat (20) @(negedge sys_clk);
        check(muxed_addr_data_out, snap);
        powerdown_req = 0;
        $display("test idle powerdown done");
        pace = 1;
        do_req(0, 0, 20'h00010, 2'b11, 16'h0000);
        reset_input_n = 0;
        notes.delete();
        repeat (8) @(negedge sys_clk);
        check({reset_indicator, strobe_oe, muxed_addr_data_oe, lock_weak_high},
              {2'b10, 16'h0000, 1'b1});
        reset_input_n = 1;
        fetch_check();
        $display("test reset abort done");
        addr_msb_float_select_in = 0;
        reset_input_n = 0;
        repeat (8) @(negedge sys_clk);
        check({all_float_test_mode, strobe_oe, lock_oe, muxed_addr_data_oe}, 19'h40000);
        check({cycle_status_oe, upper_byte_enable_oe, xcvr_data_enable_oe,
               buffer_direction_oe, upper_address_oe}, 8'h00);
        $display("test all float done");
        report_and_stop();
    end
endmodule
`default_nettype wire
